// file: src/lsp_pkg.sv
// constants shared by the shared-function port blocks
// assumes an 8-bit cpu bus with separate s1/s2 bus-cycle state strobes
//
// What this block does
// RL1 - port1 has eight pins, each input or output by its own direction bit
// RL2 - segment select set means the pin carries the lcd segment signal
// RL3 - reset clears port1 latch, direction and segment-select registers
// RL4 - direction and segment select both zero: read returns live pin level
// RL5 - direction zero with segment select one: read returns zero
// RL6 - direction one: read returns stored output latch bit
// RL7 - software clears direction and segment select for uart or interrupt inputs
// RL8 - software sets direction and latch, clears segment select, for uart output
// RL9 - port2 latch resets to ones; software keeps it one for inputs
// RL10 - port2 latch and port2 pin levels read at separate addresses
// RL11 - port2 reads leave bits seven to three undefined
// RL12 - dual-clock mode hands port2 bits one and two to the crystal
// RL13 - driving the stop release pin still flags its falling edges
// RL14 - in stop mode the stop release pin floats regardless of enable
// RL15 - output pins hold a latch; inputs are read live at sampling
// RL16 - pin data sampled in s1 of a port read cycle
// RL17 - output pins updated in s2 of a port write cycle
// RL18 - read-modify-write sees pin levels for input bits
// RL19 - software avoids rmw on write-only registers and reserved addresses
// RL20 - lcd segment drive passes to the pin unchanged under segment select
package lsp_pkg;

    // ------------------------------------------------------------------
    // bus shape
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int P1_W   = 8;
    localparam int P2_W   = 3;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_P1_LATCH  = 12'h001;
    localparam logic [ADDR_W-1:0] ADDR_P2_LATCH  = 12'h002;
    localparam logic [ADDR_W-1:0] ADDR_P1_DIR    = 12'h009;
    localparam logic [ADDR_W-1:0] ADDR_P2_LEVELS = 12'hf9c;
    localparam logic [ADDR_W-1:0] ADDR_P1_SEG    = 12'hf9e;

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [P1_W-1:0]   P1_LATCH_RST = 8'h00;
    localparam logic [P1_W-1:0]   P1_DIR_RST   = 8'h00;
    localparam logic [P1_W-1:0]   P1_SEG_RST   = 8'h00;
    localparam logic [P2_W-1:0]   P2_LATCH_RST = 3'h7;
    localparam logic [DATA_W-1:0] RDATA_RST    = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_RD  = 8'h00;
    localparam int                P2_STOP_BIT  = 0;
    localparam int                P2_XIN_BIT   = 1;
    localparam int                P2_XOUT_BIT  = 2;

endpackage : lsp_pkg

// file: src/lsp_p1_cell.sv
// one port1 pin: output value and enable, registered
// assumes direction, segment select and latch come from the cpu registers
`timescale 1ns/1ps
module lsp_p1_cell (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    // control
    input  wire logic dir_in,
    input  wire logic seg_sel_in,
    input  wire logic latch_in,
    input  wire logic lcd_seg_in,
    // pin
    output logic      pin_out,
    output logic      pin_oe_out
);
    // segment drive overrides latch and direction
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_out    <= 1'b0;
            pin_oe_out <= 1'b0;
        end else begin
            pin_out    <= seg_sel_in ? lcd_seg_in : latch_in; // see RL2 see RL20
            pin_oe_out <= seg_sel_in | dir_in;                // see RL1
        end
    end
endmodule : lsp_p1_cell

// file: src/lsp_p2_cell.sv
// one port2 pin: sink open-drain style driver, registered
// assumes a latch of one means released so the pin may serve as input
`timescale 1ns/1ps
module lsp_p2_cell (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    // control
    input  wire logic latch_in,
    input  wire logic force_hiz_in,
    // pin
    output logic      pin_out,
    output logic      pin_oe_out
);
    // only a zero latch pulls the pin; a one leaves it to the outside
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_out    <= 1'b0;
            pin_oe_out <= 1'b0;
        end else begin
            pin_out    <= 1'b0;
            pin_oe_out <= ~latch_in & ~force_hiz_in; // see RL9
        end
    end
endmodule : lsp_p2_cell

// file: src/lsp_ports.sv
// port1 and port2 with latches, direction, segment select and read mux
// assumes cpu strobes s1/s2 inside each bus cycle, all inputs synchronous
`timescale 1ns/1ps
module lsp_ports
    import lsp_pkg::*;
#(
    parameter int P1_WIDTH = lsp_pkg::P1_W,
    parameter int P2_WIDTH = lsp_pkg::P2_W
) (
    // clock and reset
    input  wire logic                       clock_in,
    input  wire logic                       rst_b_in,
    // cpu bus
    input  wire logic [lsp_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [lsp_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                       rd_cycle_in,
    input  wire logic                       wr_cycle_in,
    input  wire logic                       state_s1_in,
    input  wire logic                       state_s2_in,
    output logic      [lsp_pkg::DATA_W-1:0] rdata_out,
    output logic                            rdata_valid_out,
    // port1 pins and lcd segment drive
    input  wire logic [P1_WIDTH-1:0]        port1_pin_in,
    output logic      [P1_WIDTH-1:0]        port1_pin_out,
    output logic      [P1_WIDTH-1:0]        port1_pin_oe_out,
    input  wire logic [P1_WIDTH-1:0]        lcd_seg_in,
    // port2 pins and modes
    input  wire logic [P2_WIDTH-1:0]        port2_pin_in,
    output logic      [P2_WIDTH-1:0]        port2_pin_out,
    output logic      [P2_WIDTH-1:0]        port2_pin_oe_out,
    input  wire logic                       dual_clock_mode_in,
    input  wire logic                       stop_mode_in,
    output logic                            stop_release_fall_out
);
    import lsp_pkg::*;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [P1_WIDTH-1:0] port1_output_latch_reg;
    logic [P1_WIDTH-1:0] port1_direction_bits_reg;
    logic [P1_WIDTH-1:0] port1_segment_select_reg;
    logic [P2_WIDTH-1:0] port2_output_latch_reg;
    logic                stop_level_reg;
    logic [DATA_W-1:0]   rdata_next;
    logic [P1_WIDTH-1:0] port1_read_view;
    logic                rd_take;
    logic                wr_take;
    logic [P2_WIDTH-1:0] p2_force_hiz;

    // bus strobes: sample in s1, update in s2
    assign rd_take = rd_cycle_in & state_s1_in; // see RL16
    assign wr_take = wr_cycle_in & state_s2_in; // see RL17

    // ------------------------------------------------------------------
    // port1 registers
    // ------------------------------------------------------------------
    // written latch holds the data until rewritten
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            port1_output_latch_reg <= P1_LATCH_RST; // see RL3
        end else if (wr_take && addr_in == ADDR_P1_LATCH) begin
            port1_output_latch_reg <= wdata_in[P1_WIDTH-1:0]; // see RL15
        end
    end

    // direction bits
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            port1_direction_bits_reg <= P1_DIR_RST; // see RL3
        end else if (wr_take && addr_in == ADDR_P1_DIR) begin
            port1_direction_bits_reg <= wdata_in[P1_WIDTH-1:0]; // see RL1
        end
    end

    // segment select bits
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            port1_segment_select_reg <= P1_SEG_RST; // see RL3
        end else if (wr_take && addr_in == ADDR_P1_SEG) begin
            port1_segment_select_reg <= wdata_in[P1_WIDTH-1:0]; // see RL2
        end
    end

    // ------------------------------------------------------------------
    // port2 register
    // ------------------------------------------------------------------
    // resets to ones so every pin starts released
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            port2_output_latch_reg <= P2_LATCH_RST; // see RL9
        end else if (wr_take && addr_in == ADDR_P2_LATCH) begin
            port2_output_latch_reg <= wdata_in[P2_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < P1_WIDTH; gi++) begin : g_p1
            lsp_p1_cell u_cell (
                .clock_in   (clock_in),
                .rst_b_in   (rst_b_in),
                .dir_in     (port1_direction_bits_reg[gi]),
                .seg_sel_in (port1_segment_select_reg[gi]),
                .latch_in   (port1_output_latch_reg[gi]),
                .lcd_seg_in (lcd_seg_in[gi]),
                .pin_out    (port1_pin_out[gi]),
                .pin_oe_out (port1_pin_oe_out[gi])
            );
        end
    endgenerate

    // crystal pins and stop pin float when their special use takes over
    always_comb begin
        p2_force_hiz = '0;
        p2_force_hiz[P2_XIN_BIT]  = dual_clock_mode_in; // see RL12
        p2_force_hiz[P2_XOUT_BIT] = dual_clock_mode_in; // see RL12
        p2_force_hiz[P2_STOP_BIT] = stop_mode_in;       // see RL14
    end

    generate
        for (gi = 0; gi < P2_WIDTH; gi++) begin : g_p2
            lsp_p2_cell u_cell (
                .clock_in     (clock_in),
                .rst_b_in     (rst_b_in),
                .latch_in     (port2_output_latch_reg[gi]),
                .force_hiz_in (p2_force_hiz[gi]),
                .pin_out      (port2_pin_out[gi]),
                .pin_oe_out   (port2_pin_oe_out[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // stop release edge
    // ------------------------------------------------------------------
    // the pin input sees the wire, so a self-driven low also flags an edge
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stop_level_reg        <= 1'b1;
            stop_release_fall_out <= 1'b0;
        end else begin
            stop_level_reg        <= port2_pin_in[P2_STOP_BIT];
            stop_release_fall_out <= stop_level_reg & ~port2_pin_in[P2_STOP_BIT]; // see RL13
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // output bits read the latch, input bits the pin, segment inputs zero;
    // a bit operation writing this back rewrites input-bit latches
    always_comb begin
        for (int i = 0; i < P1_WIDTH; i++) begin
            if (port1_direction_bits_reg[i]) begin
                port1_read_view[i] = port1_output_latch_reg[i]; // see RL6
            end else if (port1_segment_select_reg[i]) begin
                port1_read_view[i] = 1'b0;                      // see RL5
            end else begin
                port1_read_view[i] = port1_pin_in[i];           // see RL4 see RL18
            end
        end
    end

    // upper port2 bits are undefined; zero is as good as any value
    always_comb begin
        rdata_next = UNMAPPED_RD;
        case (addr_in)
            ADDR_P1_LATCH: begin
                rdata_next[P1_WIDTH-1:0] = port1_read_view;
            end
            ADDR_P1_DIR: begin
                rdata_next[P1_WIDTH-1:0] = port1_direction_bits_reg;
            end
            ADDR_P1_SEG: begin
                rdata_next[P1_WIDTH-1:0] = port1_segment_select_reg;
            end
            ADDR_P2_LATCH: begin
                rdata_next[P2_WIDTH-1:0] = port2_output_latch_reg; // see RL10 see RL11
            end
            ADDR_P2_LEVELS: begin
                rdata_next[P2_WIDTH-1:0] = port2_pin_in;           // see RL10 see RL11
            end
            default: begin
                rdata_next = UNMAPPED_RD;
            end
        endcase
    end

    // read data captured at s1 and held until the next read
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out       <= RDATA_RST;
            rdata_valid_out <= 1'b0;
        end else begin
            rdata_valid_out <= rd_take;          // see RL16
            if (rd_take) begin
                rdata_out <= rdata_next;         // see RL15
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_seg_drive;
        @(posedge clock_in) disable iff (!rst_b_in)
        port1_segment_select_reg[0] |=> (port1_pin_oe_out[0]
            && port1_pin_out[0] == $past(lcd_seg_in[0]));
    endproperty
    a_seg_drive: assert property (p_seg_drive) else $error("segment drive wrong"); // see RL2

    property p_dir_drive;
        @(posedge clock_in) disable iff (!rst_b_in)
        (port1_direction_bits_reg[1] && !port1_segment_select_reg[1]) |=>
            (port1_pin_oe_out[1] && port1_pin_out[1] == $past(port1_output_latch_reg[1]));
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("output bit not driven"); // see RL1

    property p_input_float;
        @(posedge clock_in) disable iff (!rst_b_in)
        (!port1_direction_bits_reg[2] && !port1_segment_select_reg[2]) |=>
            !port1_pin_oe_out[2];
    endproperty
    a_input_float: assert property (p_input_float) else $error("input bit driven"); // see RL1

    property p_rd_pin;
        @(posedge clock_in) disable iff (!rst_b_in)
        (rd_take && addr_in == ADDR_P1_LATCH && !port1_direction_bits_reg[3]
            && !port1_segment_select_reg[3]) |=>
            (rdata_valid_out && rdata_out[3] == $past(port1_pin_in[3]));
    endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("input read not pin"); // see RL4

    property p_rd_zero;
        @(posedge clock_in) disable iff (!rst_b_in)
        (rd_take && addr_in == ADDR_P1_LATCH && !port1_direction_bits_reg[0]
            && port1_segment_select_reg[0]) |=> rdata_out[0] == 1'b0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("segment bit read not zero"); // see RL5

    property p_rd_latch;
        @(posedge clock_in) disable iff (!rst_b_in)
        (rd_take && addr_in == ADDR_P1_LATCH && port1_direction_bits_reg[5]) |=>
            rdata_out[5] == $past(port1_output_latch_reg[5]);
    endproperty
    a_rd_latch: assert property (p_rd_latch) else $error("output read not latch"); // see RL6

    property p_p2_levels;
        @(posedge clock_in) disable iff (!rst_b_in)
        (rd_take && addr_in == ADDR_P2_LEVELS) |=>
            rdata_out[P2_WIDTH-1:0] == $past(port2_pin_in);
    endproperty
    a_p2_levels: assert property (p_p2_levels) else $error("port2 level read wrong"); // see RL10

    property p_write_s2;
        @(posedge clock_in) disable iff (!rst_b_in)
        (wr_take && addr_in == ADDR_P1_LATCH && port1_direction_bits_reg[6]
            && !port1_segment_select_reg[6]) ##1 (port1_direction_bits_reg[6]
            && !port1_segment_select_reg[6]) |=> port1_pin_out[6] == $past(wdata_in[6], 2);
    endproperty
    a_write_s2: assert property (p_write_s2) else $error("write not on pin"); // see RL17

    property p_stop_hiz;
        @(posedge clock_in) disable iff (!rst_b_in)
        stop_mode_in |=> !port2_pin_oe_out[P2_STOP_BIT];
    endproperty
    a_stop_hiz: assert property (p_stop_hiz) else $error("stop pin driven in stop"); // see RL14

    property p_xtal_hiz;
        @(posedge clock_in) disable iff (!rst_b_in)
        dual_clock_mode_in |=> (!port2_pin_oe_out[P2_XIN_BIT]
            && !port2_pin_oe_out[P2_XOUT_BIT]);
    endproperty
    a_xtal_hiz: assert property (p_xtal_hiz) else $error("crystal pin driven"); // see RL12

    property p_stop_fall;
        @(posedge clock_in) disable iff (!rst_b_in)
        (port2_pin_in[P2_STOP_BIT] ##1 !port2_pin_in[P2_STOP_BIT]) |=>
            stop_release_fall_out;
    endproperty
    a_stop_fall: assert property (p_stop_fall) else $error("stop edge missed"); // see RL13

    property p_no_write_no_change;
        @(posedge clock_in) disable iff (!rst_b_in)
        !wr_take |=> $stable(port2_output_latch_reg);
    endproperty
    a_no_write_no_change: assert property (p_no_write_no_change)
        else $error("port2 latch moved without write"); // see RL9

    c_seg_mode: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        port1_segment_select_reg[0] ##1 port1_pin_oe_out[0]);
    c_p2_drive: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        port2_pin_oe_out[P2_STOP_BIT]);
    c_read_p1: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        rd_take && addr_in == ADDR_P1_LATCH);
    c_stop_fall: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        stop_release_fall_out);

endmodule : lsp_ports

// file: dv/lsp_board_model.sv
// board-side model of the port pins: external drivers and port2 sink-only wiring
// assumes the bench sets the external drive values between bus cycles
`timescale 1ns/1ps
module lsp_board_model (
    // design drive
    input  wire logic [7:0] p1_out_in,
    input  wire logic [7:0] p1_oe_in,
    input  wire logic [2:0] p2_oe_in,
    // external drive from the bench
    input  wire logic [7:0] p1_ext_in,
    input  wire logic [2:0] p2_ext_in,
    // resolved wire levels
    output logic      [7:0] p1_wire_out,
    output logic      [2:0] p2_wire_out
);
    // port1: a driving pin wins, the board drives the inputs
    always_comb begin
        p1_wire_out = (p1_oe_in & p1_out_in) | (~p1_oe_in & p1_ext_in);
    end
    // port2: sink only, a released line follows the external level from the bench
    always_comb begin
        p2_wire_out = ~p2_oe_in & p2_ext_in;
    end
endmodule : lsp_board_model

// file: dv/lcd_shared_io_ports_test.sv
// self-checking bench for the shared-function port blocks
// assumes the board model resolves every pin wire for the design
`timescale 1ns/1ps
module lcd_shared_io_ports_test;
    import lsp_pkg::*;
    logic              clock_in = 1'b0;
    logic              rst_b_in = 1'b0;
    logic [ADDR_W-1:0] addr     = '0;
    logic [7:0]        wdata    = 8'h00;
    logic              rd_cyc   = 1'b0;
    logic              wr_cyc   = 1'b0;
    logic              s1       = 1'b0;
    logic              s2       = 1'b0;
    logic [7:0]        lcd_seg  = 8'h00;
    logic [7:0]        p1_ext   = 8'h3c;
    logic [2:0]        p2_ext   = 3'h7;
    logic              dual     = 1'b0;
    logic              stop     = 1'b0;
    logic [7:0]        rdata, p1_out, p1_oe, p1_wire, d;
    logic [2:0]        p2_out, p2_oe, p2_wire;
    logic              rvalid, fall;
    int                n_fail = 0;
    int                check_count = 0;
    int                cnt;

    always #10 clock_in = ~clock_in;

    lsp_ports lsp_ports_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr),
        .wdata_in(wdata), .rd_cycle_in(rd_cyc), .wr_cycle_in(wr_cyc), .state_s1_in(s1),
        .state_s2_in(s2), .rdata_out(rdata), .rdata_valid_out(rvalid),
        .port1_pin_in(p1_wire), .port1_pin_out(p1_out), .port1_pin_oe_out(p1_oe),
        .lcd_seg_in(lcd_seg), .port2_pin_in(p2_wire), .port2_pin_out(p2_out),
        .port2_pin_oe_out(p2_oe), .dual_clock_mode_in(dual), .stop_mode_in(stop),
        .stop_release_fall_out(fall));
    lsp_board_model lsp_board_model_inst (.p1_out_in(p1_out), .p1_oe_in(p1_oe),
        .p2_oe_in(p2_oe), .p1_ext_in(p1_ext), .p2_ext_in(p2_ext),
        .p1_wire_out(p1_wire), .p2_wire_out(p2_wire));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // write taken at the edge where wr_cycle and s2 are both high
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(negedge clock_in);
        addr = a;
        wdata = v;
        wr_cyc = 1'b1;
        s2 = 1'b1;
        @(negedge clock_in);
        wr_cyc = 1'b0;
        s2 = 1'b0;
    endtask : wr

    // chg flips board pins just after the sampling edge
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] chg);
        int i;
        @(negedge clock_in);
        addr = a;
        rd_cyc = 1'b1;
        s1 = 1'b1;
        @(negedge clock_in);
        rd_cyc = 1'b0;
        s1 = 1'b0;
        p1_ext = p1_ext ^ chg;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clock_in);
        if (i == 4) begin
            n_fail++;
            close_out();
        end else begin
            d = rdata;
        end
    endtask : rd

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
                       input logic [7:0] mask, input logic [7:0] chg);
        rd(a, chg);
        chk(d & mask, exp);
    endtask : rdc

    task automatic settle;
        repeat (2) @(negedge clock_in);
    endtask : settle

    task automatic reset_checks;
        chk(p1_oe, 8'h00);
        chk(p1_out, 8'h00);
        chk({5'h00, p2_oe}, 8'h00);
        chk({5'h00, p2_out}, 8'h00);
        rdc(ADDR_P1_DIR, P1_DIR_RST, 8'hff, 8'h00);
        rdc(ADDR_P1_SEG, 8'h00, 8'hff, 8'h00);
        rdc(ADDR_P2_LATCH, 8'h07, 8'h07, 8'h00);
        $display("test reset done");
    endtask : reset_checks

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clock_in);
        rst_b_in = 1'b1;
        reset_checks();
        // mixed direction: outputs from latch, inputs live at the edge
        wr(ADDR_P1_DIR, 8'hf0);
        wr(ADDR_P1_LATCH, 8'ha5);
        settle();
        chk(p1_oe, 8'hf0);
        chk(p1_out & p1_oe, 8'ha0);
        rdc(ADDR_P1_LATCH, 8'hac, 8'hff, 8'h0f);
        rdc(ADDR_P1_LATCH, 8'ha3, 8'hff, 8'h00);
        $display("test direction done");
        // segment select overrides both direction and latch
        lcd_seg = 8'h82;
        p1_ext = 8'h0c;
        wr(ADDR_P1_SEG, 8'h83);
        settle();
        chk(p1_oe, 8'hf3);
        chk(p1_out & p1_oe, 8'ha2);
        lcd_seg = 8'h01;
        settle();
        chk(p1_out & p1_oe, 8'h21);
        rdc(ADDR_P1_LATCH, 8'hac, 8'hff, 8'h00);
        rdc(ADDR_P1_DIR, 8'hf0, 8'hff, 8'h00);
        rdc(ADDR_P1_SEG, 8'h83, 8'hff, 8'h00);
        $display("test segment done");
        // bit set by read-modify-write copies input pins into the latch
        wr(ADDR_P1_SEG, 8'h00);
        rdc(ADDR_P1_LATCH, 8'hac, 8'hff, 8'h00);
        wr(ADDR_P1_LATCH, d | 8'h01);
        wr(ADDR_P1_DIR, 8'hff);
        settle();
        chk(p1_out, 8'had);
        chk(p1_oe, 8'hff);
        $display("test rmw done");
        // port2: latch, pin levels, stop edge, stop and dual-clock modes
        wr(ADDR_P2_LATCH, 8'h06);
        cnt = 0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clock_in);
            if (fall === 1'b1) cnt++;
        end
        chk(cnt[7:0], 8'h01);
        chk({5'h00, p2_oe}, 8'h01);
        rdc(ADDR_P2_LATCH, 8'h06, 8'h07, 8'h00);
        rdc(ADDR_P2_LEVELS, 8'h06, 8'h07, 8'h00);
        p2_ext = 3'h3;
        rdc(ADDR_P2_LEVELS, 8'h02, 8'h07, 8'h00);
        p2_ext = 3'h7;
        stop = 1'b1;
        settle();
        chk({5'h00, p2_oe}, 8'h00);
        stop = 1'b0;
        wr(ADDR_P2_LATCH, 8'h00);
        settle();
        chk({5'h00, p2_oe}, 8'h07);
        dual = 1'b1;
        settle();
        chk({5'h00, p2_oe}, 8'h01);
        dual = 1'b0;
        wr(ADDR_P2_LATCH, 8'h07);
        $display("test port2 done");
        // unmapped place: write ignored, read gives zero
        wr(12'h003, 8'hff);
        rdc(12'h003, UNMAPPED_RD, 8'hff, 8'h00);
        rdc(ADDR_P1_DIR, 8'hff, 8'hff, 8'h00);
        $display("test unmapped done");
        // second reset in mid-run
        rst_b_in = 1'b0;
        settle();
        rst_b_in = 1'b1;
        reset_checks();
        close_out();
    end
endmodule : lcd_shared_io_ports_test
